// ===== aws_pkg.sv
// Package: register map, field layout and timing constants of the auto wake/sleep controller
package aws_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the bus are index times four)
    // ------------------------------------------------------------------
    localparam logic [7:0] AWS_IDX_LIMIT_LOW  = 8'h1E;
    localparam logic [7:0] AWS_IDX_LIMIT_HIGH = 8'h1F;
    localparam logic [7:0] AWS_IDX_CONFIG     = 8'h30;
    localparam logic [7:0] AWS_IDX_STATUS     = 8'h31;
    localparam int         AWS_ADDR_W         = 10;
    localparam logic [7:0] AWS_LIMIT_RESET    = 8'h00;
    localparam logic [3:0] AWS_HIGH_MASK      = 4'hF;

    // ------------------------------------------------------------------
    // Config register field layout
    // ------------------------------------------------------------------
    localparam int AWS_CFG_ACT_PM_LSB   = 0;   // active_power_select [1:0]
    localparam int AWS_CFG_LOW_PM_LSB   = 2;   // lowrate_power_select [1:0]
    localparam int AWS_CFG_ACT_ODR_LSB  = 4;   // active_rate_select [3:0]
    localparam int AWS_CFG_LOW_ODR_LSB  = 8;   // lowrate_rate_select [3:0]
    localparam int AWS_CFG_ACT_DEC_LSB  = 12;  // active_decimation [3:0]
    localparam int AWS_CFG_LOW_DEC_LSB  = 16;  // lowrate_decimation [3:0]
    localparam int AWS_CFG_EN_LSB       = 20;  // detection enables [3:0]
    localparam int AWS_CFG_KEEP_BIT     = 24;  // buffer_read_keeps_awake
    localparam logic [31:0] AWS_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] AWS_CFG_MASK  = 32'h01FF_FFFF;

    // Status register: bit0 lowrate mode, bits 27:16 counter
    localparam int AWS_STS_CNT_LSB = 16;

    // ------------------------------------------------------------------
    // Timing: idle unit and sample periods
    // ------------------------------------------------------------------
    localparam real AWS_CLK_MHZ      = 200.0;
    localparam real AWS_IDLE_UNIT_US = 312.5;
    localparam int  AWS_IDLE_UNIT_CYC = int'(AWS_IDLE_UNIT_US * AWS_CLK_MHZ);
    localparam real AWS_BASE_PERIOD_US = 312.5;  // 3200 Hz period, code 0
    localparam int  AWS_BASE_CYC = int'(AWS_BASE_PERIOD_US * AWS_CLK_MHZ);
    localparam int  AWS_DEC_UNIT_CYC = AWS_BASE_CYC;   // measure time per decimation step

    // Power mode encodings; 2'b1x is flexible
    localparam logic [1:0] AWS_PM_LOW_POWER = 2'h0;
    localparam logic [1:0] AWS_PM_HIGH_PERF = 2'h1;

    typedef enum logic {AWS_ACTIVE, AWS_LOWRATE} aws_mode_e;

    // Event flags from the sources
    typedef struct packed {
        logic data_ready_flag;
        logic overflow_flag;
        logic buffer_event_flag;
        logic change_outside_flag;
        logic change_within_flag;
        logic orientation_flag;
        logic auto_sleep_flag;
        logic boot_done_flag;
    } aws_events_s;

    // Settings applied to the sampling engine
    typedef struct packed {
        logic [1:0]  power_select;
        logic [3:0]  rate_select;
        logic [3:0]  decimation;
        logic [11:0] idle_time;
    } aws_setting_s;
endpackage

// ===== aws_period_gen.sv
// Period tick generator: one pulse per active-mode sample period
`timescale 1ns/1ps
`default_nettype none
module aws_period_gen #(
    parameter int CNT_W = 32
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                run,
    input  wire logic [CNT_W-1:0]    period_cyc,
    output logic                     tick
);
    import aws_pkg::*;

    // Elaboration check: a narrower counter cannot span a slow sample period
    if (CNT_W < 24) begin : g_width_check
        $error("aws_period_gen: CNT_W too small");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             tick_reg;
    logic             tick_next;

    // Count up; reload zero on terminal, hold cleared while not running
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!run) begin
            cnt_next = '0;
        end else if (cnt_reg + 1'b1 >= period_cyc) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

// ===== aws_ctrl.sv
// Auto wake/sleep controller top with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module aws_ctrl (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [9:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    output logic [1:0]                      avs_response,
    input  wire aws_pkg::aws_events_s       events,
    input  wire logic                       buffer_flag_cleared,
    output aws_pkg::aws_setting_s           setting,
    output logic                            lowrate_mode,
    output logic                            mode_changed
);
    import aws_pkg::*;

    localparam int PW = 32;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]  lim_low_reg,  lim_low_next;
    logic [3:0]  lim_high_reg, lim_high_next;
    logic [31:0] cfg_reg,      cfg_next;
    logic [31:0] rdata_reg,    rdata_next;
    logic        ack_reg,      ack_next;
    logic [1:0]  resp_reg,     resp_next;

    // ------------------------------------------------------------------
    // Mode and counter state
    // ------------------------------------------------------------------
    aws_mode_e     mode_reg,    mode_next;
    logic [11:0]   count_reg,   count_next;
    logic          chg_reg,     chg_next;
    aws_setting_s  set_reg,     set_next;

    logic [11:0]   limit;
    logic [3:0]    det_en;
    logic          keep_awake;
    logic          tick;
    logic [PW-1:0] period_cyc;
    logic          activity;
    logic          wake_evt;
    logic [7:0]    idx;
    logic          sel_hit;

    assign limit      = {lim_high_reg, lim_low_reg};
    assign det_en     = cfg_reg[AWS_CFG_EN_LSB +: 4];
    assign keep_awake = cfg_reg[AWS_CFG_KEEP_BIT];
    assign idx        = avs_address[9:2];

    // ------------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------------
    // det_en: 0 buffer, 1 change outside, 2 change within, 3 orientation.
    // Data-ready, overflow, auto-sleep and boot never take part.       
    always_comb begin
        wake_evt = (det_en[1] & events.change_outside_flag)
                 | (det_en[2] & events.change_within_flag)
                 | (det_en[3] & events.orientation_flag);
        // Buffer only restarts, and only via the host clear when kept awake
        activity = wake_evt
                 | (det_en[0] & keep_awake & buffer_flag_cleared);
    end

    // ------------------------------------------------------------------
    // Period of one inactivity count in clock cycles
    // ------------------------------------------------------------------
    // Flexible: measure time from decimation plus idle units of 312.5 us
    always_comb begin
        if (cfg_reg[AWS_CFG_ACT_PM_LSB + 1]) begin
            period_cyc = PW'(AWS_DEC_UNIT_CYC)
                           * PW'(cfg_reg[AWS_CFG_ACT_DEC_LSB +: 4] + 5'h01)
                       + PW'(AWS_IDLE_UNIT_CYC) * PW'(set_reg.idle_time);
        end else begin
            period_cyc = PW'(AWS_BASE_CYC) << cfg_reg[AWS_CFG_ACT_ODR_LSB +: 4];
        end
    end

    aws_period_gen #(
        .CNT_W      (PW)
    ) u_period (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (mode_reg == AWS_ACTIVE),
        .period_cyc (period_cyc),
        .tick       (tick)
    );

    // ------------------------------------------------------------------
    // Mode machine and inactivity counter
    // ------------------------------------------------------------------
    // Idle times have no register in this block; set_next ties idle_time
    // to zero, so flexible period is decimation-only unless extended later.
    always_comb begin
        mode_next  = mode_reg;
        count_next = count_reg;
        chg_next   = 1'b0;
        unique case (mode_reg)
            AWS_ACTIVE: begin
                if (limit == 12'h000 || activity) begin
                    count_next = 12'h000;
                end else if (tick) begin
                    if (count_reg + 12'h001 >= limit) begin
                        mode_next  = AWS_LOWRATE;
                        count_next = 12'h000;
                        chg_next   = 1'b1;
                    end else begin
                        count_next = count_reg + 12'h001;
                    end
                end
            end
            AWS_LOWRATE: begin
                count_next = 12'h000;
                if (wake_evt || limit == 12'h000) begin
                    mode_next = AWS_ACTIVE;
                    chg_next  = 1'b1;
                end
            end
        endcase
    end

    // Applied settings follow the mode being entered
    always_comb begin
        set_next = set_reg;
        if (mode_next == AWS_ACTIVE) begin
            set_next.power_select = cfg_reg[AWS_CFG_ACT_PM_LSB +: 2];
            set_next.rate_select  = cfg_reg[AWS_CFG_ACT_ODR_LSB +: 4];
            set_next.decimation   = cfg_reg[AWS_CFG_ACT_DEC_LSB +: 4];
        end else begin
            set_next.power_select = cfg_reg[AWS_CFG_LOW_PM_LSB +: 2];
            set_next.rate_select  = cfg_reg[AWS_CFG_LOW_ODR_LSB +: 4];
            set_next.decimation   = cfg_reg[AWS_CFG_LOW_DEC_LSB +: 4];
        end
        set_next.idle_time = 12'h000;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg  <= AWS_ACTIVE;
            count_reg <= 12'h000;
            chg_reg   <= 1'b0;
            set_reg   <= '0;
        end else begin
            mode_reg  <= mode_next;
            count_reg <= count_next;
            chg_reg   <= chg_next;
            set_reg   <= set_next;
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, answer on the second edge
    // ------------------------------------------------------------------
    // A fixed single wait state keeps the read mux off the critical path.
    always_comb begin
        lim_low_next  = lim_low_reg;
        lim_high_next = lim_high_reg;
        cfg_next      = cfg_reg;
        rdata_next    = rdata_reg;
        resp_next     = resp_reg;
        ack_next      = 1'b0;
        sel_hit       = 1'b1;
        if (avs_read || avs_write) begin
            ack_next   = !ack_reg;                  // Second cycle is the answer
            rdata_next = 32'h0000_0000;
            unique case (idx)
                AWS_IDX_LIMIT_LOW: begin
                    rdata_next[7:0] = lim_low_reg;
                    if (avs_write && ack_reg && avs_byteenable[0]) begin
                        lim_low_next = avs_writedata[7:0];
                    end
                end
                AWS_IDX_LIMIT_HIGH: begin
                    rdata_next[3:0] = lim_high_reg;
                    if (avs_write && ack_reg && avs_byteenable[0]) begin
                        lim_high_next = avs_writedata[3:0] & AWS_HIGH_MASK;
                    end
                end
                AWS_IDX_CONFIG: begin
                    rdata_next = cfg_reg;
                    for (int b = 0; b < 4; b++) begin
                        if (avs_write && ack_reg && avs_byteenable[b]) begin
                            cfg_next[8*b +: 8] = avs_writedata[8*b +: 8]
                                               & AWS_CFG_MASK[8*b +: 8];
                        end
                    end
                end
                AWS_IDX_STATUS: begin
                    rdata_next[0] = (mode_reg == AWS_LOWRATE);
                    rdata_next[AWS_STS_CNT_LSB +: 12] = count_reg;
                end
                default: begin
                    sel_hit = 1'b0;
                end
            endcase
            // Writes land in the answer cycle, where the master sees waitrequest low;
            // readback and response chosen in the first cycle stand through it
            if (ack_reg) begin
                rdata_next = rdata_reg;
            end
            resp_next = ack_reg ? resp_reg : (sel_hit ? 2'b00 : 2'b11); // Unmapped: error
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lim_low_reg  <= AWS_LIMIT_RESET;
            lim_high_reg <= 4'h0;
            cfg_reg      <= AWS_CFG_RESET;
            rdata_reg    <= 32'h0000_0000;
            ack_reg      <= 1'b0;
            resp_reg     <= 2'b00;
        end else begin
            lim_low_reg  <= lim_low_next;
            lim_high_reg <= lim_high_next;
            cfg_reg      <= cfg_next;
            rdata_reg    <= rdata_next;
            ack_reg      <= ack_next;
            resp_reg     <= resp_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops (waitrequest is the inverse of ack)
    // ------------------------------------------------------------------
    logic wait_reg, wait_next;
    assign wait_next = !((avs_read || avs_write) && !ack_reg);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= wait_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;
    assign avs_response    = resp_reg;
    assign setting         = set_reg;
    assign lowrate_mode    = (mode_reg == AWS_LOWRATE);
    assign mode_changed    = chg_reg;
endmodule
`default_nettype wire

// ===== aws_ctrl_monitor.sv
// Checker of the auto wake/sleep controller port behaviour
`timescale 1ns/1ps
`default_nettype none
module aws_ctrl_monitor (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic [9:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic [3:0]           avs_byteenable,
    input wire logic                 avs_waitrequest,
    input wire logic [1:0]           avs_response,
    input wire aws_pkg::aws_events_s events,
    input wire logic                 lowrate_mode,
    input wire logic                 mode_changed
);
    import aws_pkg::*;
    // ------------------------------------------------------------------
    // Shadow of limit and enables, updated on the accepting edge
    // ------------------------------------------------------------------
    logic [11:0] limit_reg;
    logic [11:0] limit_next;
    logic [3:0]  en_reg;
    logic [3:0]  en_next;
    logic [7:0]  idx;
    logic        ack;
    logic        mapped;
    logic        any_ev;
    logic        wake_ev;

    // Word index, acceptance, and the two classes of wake activity
    assign idx = avs_address[9:2];
    assign ack = avs_write && !avs_waitrequest;
    assign mapped = (idx == AWS_IDX_LIMIT_LOW) || (idx == AWS_IDX_LIMIT_HIGH)
                 || (idx == AWS_IDX_CONFIG) || (idx == AWS_IDX_STATUS);
    assign any_ev = events.change_outside_flag | events.change_within_flag
                  | events.orientation_flag;
    // Buffer enable bit 0 never wakes, so it is left out here
    assign wake_ev = (events.change_outside_flag & en_reg[1])
                   | (events.change_within_flag & en_reg[2])
                   | (events.orientation_flag & en_reg[3]);

    // Next shadow values from accepted byte-lane writes
    always_comb begin
        limit_next = limit_reg;
        en_next = en_reg;
        if (ack && avs_byteenable[0] && idx == AWS_IDX_LIMIT_LOW) begin
            limit_next[7:0] = avs_writedata[7:0];
        end
        if (ack && avs_byteenable[0] && idx == AWS_IDX_LIMIT_HIGH) begin
            limit_next[11:8] = avs_writedata[3:0];
        end
        if (ack && avs_byteenable[2] && idx == AWS_IDX_CONFIG) begin
            en_next = avs_writedata[23:20];
        end
    end

    // Shadow registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_reg <= 12'h000;
            en_reg <= 4'h0;
        end else begin
            limit_reg <= limit_next;
            en_reg <= en_next;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence ans_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    bus_answer_a: assert property (req_s |=> ans_s)
        else $error("bus request not answered in one cycle");
    decode_error_a: assert property (!avs_waitrequest && !mapped |-> avs_response == 2'h3)
        else $error("unmapped index without decode error");
    decode_ok_a: assert property (!avs_waitrequest && mapped |-> avs_response == 2'h0)
        else $error("mapped index answered with error");
    limit_zero_a: assert property (limit_reg == 12'h000 && !lowrate_mode |=> !lowrate_mode)
        else $error("low-rate entered with zero limit");
    wake_prompt_a: assert property (lowrate_mode && wake_ev |=> !lowrate_mode)
        else $error("enabled event did not wake at once");
    // A zero limit also returns to active mode, so it is excluded here
    stay_asleep_a: assert property (lowrate_mode && !any_ev && limit_reg != 12'h000
        |=> lowrate_mode)
        else $error("woke without change or orientation event");
    change_pulse_a: assert property ($changed(lowrate_mode) |-> ##[0:1] mode_changed)
        else $error("mode change without pulse");
    // Entry then wake on consecutive edges gives two pulses, each with its own change
    pulse_single_a: assert property (mode_changed |-> $changed(lowrate_mode))
        else $error("mode change pulse without a mode change");
    quiet_entry_a: assert property ($rose(lowrate_mode)
        |-> !$past(wake_ev) && $past(limit_reg) != 12'h000)
        else $error("low-rate entered despite activity or zero limit");
endmodule

bind aws_ctrl aws_ctrl_monitor mon (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .events(events),
    .lowrate_mode(lowrate_mode), .mode_changed(mode_changed));
`default_nettype wire

// ===== aws_ctrl_tb.sv
// Self-checking testbench of the auto wake/sleep controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module testbench;
    import aws_pkg::*;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic [9:0]    avs_address = 10'h000;
    logic          avs_read = 1'b0;
    logic          avs_write = 1'b0;
    logic [31:0]   avs_writedata = 32'h0;
    logic [3:0]    avs_byteenable = 4'hF;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    logic [1:0]    avs_response;
    aws_events_s   events = 8'h00;
    logic          buffer_flag_cleared = 1'b0;
    aws_setting_s  setting;
    logic          lowrate_mode;
    logic          mode_changed;
    int            n_fail = 0;
    int            check_count = 0;
    logic [31:0]   rd;
    logic [1:0]    rsp;

    aws_ctrl dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .events(events),
        .buffer_flag_cleared(buffer_flag_cleared), .setting(setting),
        .lowrate_mode(lowrate_mode), .mode_changed(mode_changed));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Bus tasks: each starts after an edge so no signal is set twice
    // ------------------------------------------------------------------
    // No local limit: only the watchdog ends a wait for the answer
    task automatic wait_ack();
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
    endtask

    task automatic bus_write(input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        wait_ack();
        d = avs_readdata;
        r = avs_response;
        avs_read <= 1'b0;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog: one sleep period of 62500 cycles plus margin
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        test_done();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int k;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and an unmapped index
        bus_read(AWS_IDX_LIMIT_LOW, rd, rsp);  `CHK("limit low", 32'h0, rd)
        `CHK("mapped resp", 2'h0, rsp)
        bus_read(AWS_IDX_LIMIT_HIGH, rd, rsp); `CHK("limit high", 32'h0, rd)
        bus_read(AWS_IDX_CONFIG, rd, rsp);     `CHK("config", AWS_CFG_RESET, rd)
        bus_read(8'h40, rd, rsp);              `CHK("unmapped resp", 2'h3, rsp)
        `CHK("reset mode", 1'b0, lowrate_mode)
        $display("test reset done");
        // Both limit bytes hold their value; split count
        bus_write(AWS_IDX_LIMIT_LOW, 32'h0000_00A5);
        bus_write(AWS_IDX_LIMIT_HIGH, 32'h0000_000C);
        bus_read(AWS_IDX_LIMIT_LOW, rd, rsp);  `CHK("limit low rw", 32'h0000_00A5, rd)
        bus_read(AWS_IDX_LIMIT_HIGH, rd, rsp); `CHK("limit high rw", 32'h0000_000C, rd)
        bus_write(AWS_IDX_LIMIT_LOW, 32'h0);
        bus_write(AWS_IDX_LIMIT_HIGH, 32'h0);
        $display("test limit done");
        // Zero limit: no switching; ignored flags held high meanwhile
        events <= 8'hC3;
        // Flexible active mode, decimation 0 and idle 0: still 62500 cycles a count
        bus_write(AWS_IDX_CONFIG, 32'h00F3_0506);
        bus_read(AWS_IDX_CONFIG, rd, rsp);     `CHK("config rw", 32'h00F3_0506, rd)
        `CHK("active power", 2'h2, setting.power_select)
        `CHK("active rate", 4'h0, setting.rate_select)
        `CHK("active dec", 4'h0, setting.decimation)
        buffer_flag_cleared <= 1'b1;
        @(posedge clk);
        buffer_flag_cleared <= 1'b0;
        repeat (2000) @(posedge clk);
        `CHK("disabled mode", 1'b0, lowrate_mode)
        bus_read(AWS_IDX_STATUS, rd, rsp);     `CHK("status", 32'h0, rd)
        $display("test disabled done");
        // Limit 1 with only non-qualifying flags active: sleeps after one period
        bus_write(AWS_IDX_LIMIT_LOW, 32'h0000_0001);
        k = 0;
        while (lowrate_mode !== 1'b1 && k < 70000) begin
            @(posedge clk);
            k++;
        end
        `CHK("entered low-rate", 1'b1, lowrate_mode)
        `CHK("sleep pulse", 1'b1, mode_changed)
        @(posedge clk);
        `CHK("lowrate power", 2'h1, setting.power_select)
        `CHK("lowrate rate", 4'h5, setting.rate_select)
        `CHK("lowrate dec", 4'h3, setting.decimation)
        bus_read(AWS_IDX_STATUS, rd, rsp);     `CHK("status mode", 1'b1, rd[0])
        $display("test sleep done");
        // Buffer flag alone never wakes; a change flag wakes at once
        events <= 8'hE3;
        repeat (10) @(posedge clk);
        `CHK("buffer no wake", 1'b1, lowrate_mode)
        events <= 8'hEB;
        // Second edge shows the state taken at the first: wake with no extra period
        repeat (2) @(posedge clk);
        `CHK("woken", 1'b0, lowrate_mode)
        `CHK("wake pulse", 1'b1, mode_changed)
        repeat (2) @(posedge clk);
        `CHK("rate after wake", 4'h0, setting.rate_select)
        `CHK("power after wake", 2'h2, setting.power_select)
        events <= 8'h00;
        $display("test wake done");
        test_done();
    end
endmodule
`default_nettype wire
